// *** bcp6_port.sv ***
// Behaviour
// - direction register write-only, reads all ones
// - direction resets to 80, held in sleep
// - output pins keep driving in software standby
// - output latch resets to 80, held in sleep
// - read returns latch bit when direction one
// - read returns pin level when direction zero
// - latch top bit fixed one, unwritable
// - latch bits six, two, one stored, unpinned
// - unused bits read latch or constant one
// - expanded modes drive strobes on pins five-three
// - pin zero general in single-chip mode, in expanded modes only with all stall enable bits set and select low
// - single-chip mode: direction bit picks per pin
// - modes 1,3 / 5,6 expanded, 7 single-chip
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module bcp6_port
	import bcp6_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  hw_standby,
	input  wire logic                  sw_standby,
	input  wire logic [2:0]            mode,
	input  wire bcp6_stall_s           stall_cfg,
	input  wire bcp6_strobe_s          bus_strobes,
	input  wire logic [15:0]           reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	input  wire logic [BCP6_NPINS-1:0] pin_in,
	output logic      [BCP6_NPINS-1:0] pin_out,
	output logic      [BCP6_NPINS-1:0] pin_oe,
	output logic                       bus_wait_n
);

	// ==========================================================
	// input synchronisers
	logic [BCP6_SYNC_W-1:0] sync_q;
	logic [BCP6_NPINS-1:0]  pin_s;
	logic                   hw_sb;
	logic                   init;

	bcp6_sync2 #(
		.W (BCP6_SYNC_W)
	) u_sync (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in ({hw_standby, pin_in}),
		.sync_out (sync_q)
	);

	assign pin_s = sync_q[BCP6_NPINS-1:0];
	assign hw_sb = sync_q[BCP6_SYNC_HWSB];
	assign init  = sys_rst | hw_sb;

	// ==========================================================
	// mode decode
	bcp6_mode_e mode_cls;
	logic       expanded;
	logic       pin0_general;

	always_comb
	begin
		case (mode)
			BCP6_MODE1, BCP6_MODE3: mode_cls = BCP6_EXP_NO_ROM;
			BCP6_MODE5, BCP6_MODE6: mode_cls = BCP6_EXP_WITH_ROM;
			BCP6_MODE7:             mode_cls = BCP6_SINGLE_CHIP;
			default:                mode_cls = BCP6_SINGLE_CHIP;
		endcase
	end

	assign expanded     = (mode_cls != BCP6_SINGLE_CHIP);
	// pin zero general only with all stall bits set and select low
	assign pin0_general = (stall_cfg.stall_enable_bits == BCP6_STALL_ALL)
		&& !stall_cfg.stall_mode_select_high;

	// ==========================================================
	// registers
	logic [7:0] dir_ff;
	logic [7:0] latch_ff;
	logic       wr_ok;

	assign wr_ok = reg_wr && !sw_standby;

	always_ff @(posedge sys_clk)
	begin
		if (init)
			dir_ff <= BCP6_DIR_RST;
		else if (wr_ok && reg_addr == BCP6_ADDR_DIR)
			dir_ff <= {BCP6_FIXED_ONE, reg_wdata[BCP6_TOP_BIT-1:0]};
	end

	always_ff @(posedge sys_clk)
	begin
		if (init)
			latch_ff <= BCP6_LATCH_RST;
		else if (wr_ok && reg_addr == BCP6_ADDR_LATCH)
			latch_ff <= {BCP6_FIXED_ONE, reg_wdata[BCP6_TOP_BIT-1:0]};
	end

	// ==========================================================
	// read path
	logic [7:0] port_view;
	logic [7:0] nxt_rdata;
	logic [7:0] reg_rdata_ff;

	always_comb
	begin
		// unused bits: latch if direction set, else one
		port_view = latch_ff | ~dir_ff;
		port_view[BCP6_TOP_BIT] = BCP6_FIXED_ONE;
		for (int k = 0; k < BCP6_NPINS; k++)
		begin
			if (dir_ff[BCP6_PIN_POS[k]])
				port_view[BCP6_PIN_POS[k]] = latch_ff[BCP6_PIN_POS[k]];
			else
				port_view[BCP6_PIN_POS[k]] = pin_s[k];
		end
	end

	always_comb
	begin
		case (reg_addr)
			BCP6_ADDR_DIR:   nxt_rdata = BCP6_DIR_READ;
			BCP6_ADDR_LATCH: nxt_rdata = port_view;
			default:         nxt_rdata = BCP6_UNMAP_READ;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			reg_rdata_ff <= BCP6_RDATA_RST;
		else if (reg_rd)
			reg_rdata_ff <= nxt_rdata;
		else
			reg_rdata_ff <= BCP6_RDATA_RST;
	end

	assign reg_rdata = reg_rdata_ff;

	// ==========================================================
	// pin drivers
	logic [BCP6_NPINS-1:0] strobe_vec;
	logic [BCP6_NPINS-1:0] pin_out_ff;
	logic [BCP6_NPINS-1:0] pin_oe_ff;

	assign strobe_vec = {bus_strobes.write_strobe_n, bus_strobes.read_strobe_n,
		bus_strobes.address_strobe_n, BCP6_WAIT_IDLE};

	genvar g;
	generate
		for (g = 0; g < BCP6_NPINS; g++)
		begin : g_pin
			logic nxt_out;
			logic nxt_oe;
			logic out_ff;
			logic oe_ff;

			always_comb
			begin
				if (expanded && g != BCP6_PIN_WAIT)
				begin
					nxt_out = strobe_vec[g];
					nxt_oe  = 1'b1;
				end
				else if (expanded && !pin0_general)
				begin
					nxt_out = 1'b0;
					nxt_oe  = 1'b0;
				end
				else
				begin
					nxt_out = latch_ff[BCP6_PIN_POS[g]];
					nxt_oe  = dir_ff[BCP6_PIN_POS[g]];
				end
			end

			always_ff @(posedge sys_clk)
			begin
				if (init)
				begin
					out_ff <= BCP6_PIN_IDLE[g];
					oe_ff  <= BCP6_PIN_IDLE[g];
				end
				else if (!sw_standby)
				begin
					out_ff <= nxt_out;
					oe_ff  <= nxt_oe;
				end
			end

			// one flop pair per pin, gathered into the vectors
			assign pin_out_ff[g] = out_ff;
			assign pin_oe_ff[g]  = oe_ff;
		end
	endgenerate

	assign pin_out = pin_out_ff;
	assign pin_oe  = pin_oe_ff;

	// ==========================================================
	// wait input towards the bus controller
	logic bus_wait_n_ff;

	always_ff @(posedge sys_clk)
	begin
		if (init)
			bus_wait_n_ff <= BCP6_WAIT_IDLE;
		else if (expanded && !pin0_general)
			bus_wait_n_ff <= pin_s[BCP6_PIN_WAIT];
		else
			bus_wait_n_ff <= BCP6_WAIT_IDLE;
	end

	assign bus_wait_n = bus_wait_n_ff;

	// ==========================================================
	// assertions
	a_dir_reads_ones: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(reg_rd && reg_addr == BCP6_ADDR_DIR) |=> (reg_rdata == 8'hFF))
		else $error("direction read not all ones");

	a_dir_init_val: assert property (
		@(posedge sys_clk)
		init |=> (dir_ff == 8'h80))
		else $error("direction not 80 after init");

	a_latch_init_val: assert property (
		@(posedge sys_clk)
		init |=> (latch_ff == 8'h80))
		else $error("latch not 80 after init");

	a_swsb_pins_hold: assert property (
		@(posedge sys_clk) disable iff (init)
		(sw_standby && !sys_rst && !hw_sb) |=> ($stable(pin_out_ff) && $stable(pin_oe_ff)))
		else $error("pins changed in software standby");

	a_read_latch_bit: assert property (
		@(posedge sys_clk) disable iff (init)
		(reg_rd && reg_addr == BCP6_ADDR_LATCH && dir_ff[3])
		|=> (reg_rdata[3] == $past(latch_ff[3])))
		else $error("latched bit not returned");

	a_read_pin_level: assert property (
		@(posedge sys_clk) disable iff (init)
		(reg_rd && reg_addr == BCP6_ADDR_LATCH && !dir_ff[4])
		|=> (reg_rdata[4] == $past(pin_s[2])))
		else $error("pin level not returned");

	a_top_bit_one: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(reg_rd && reg_addr == BCP6_ADDR_LATCH) |=> (reg_rdata[7] && latch_ff[7]))
		else $error("latch top bit not one");

	a_spare_bit_store: assert property (
		@(posedge sys_clk) disable iff (init)
		(wr_ok && reg_addr == BCP6_ADDR_LATCH) |=> (latch_ff[6] == $past(reg_wdata[6])))
		else $error("spare latch bit not stored");

	a_spare_bit_read: assert property (
		@(posedge sys_clk) disable iff (init)
		(reg_rd && reg_addr == BCP6_ADDR_LATCH && !dir_ff[1]) |=> reg_rdata[1])
		else $error("spare bit not one with direction zero");

	a_strobe_on_pin: assert property (
		@(posedge sys_clk) disable iff (init)
		(expanded && !sw_standby) |=> (pin_oe_ff[3] && pin_out_ff[3] == $past(bus_strobes.write_strobe_n)))
		else $error("write strobe not on pin five");

	a_wait_pin_input: assert property (
		@(posedge sys_clk) disable iff (init)
		(expanded && !pin0_general && !sw_standby) |=> !pin_oe_ff[0])
		else $error("pin zero driven while wait input");

	a_single_chip_dir: assert property (
		@(posedge sys_clk) disable iff (init)
		(mode == BCP6_MODE7 && !sw_standby)
		|=> (pin_oe_ff == {$past(dir_ff[5]), $past(dir_ff[4]), $past(dir_ff[3]), $past(dir_ff[0])}))
		else $error("single-chip drivers differ from direction");

	a_oe_needs_dir: assert property (
		@(posedge sys_clk) disable iff (init)
		(!expanded && !sw_standby) |=> (pin_oe_ff[0] == $past(dir_ff[0])))
		else $error("pin zero driver without direction");

	a_wait_level_pass: assert property (
		@(posedge sys_clk) disable iff (init)
		(expanded && !pin0_general) |=> (bus_wait_n == $past(pin_s[BCP6_PIN_WAIT])))
		else $error("wait pin level not passed on");

	a_wait_idle_high: assert property (
		@(posedge sys_clk) disable iff (init)
		(!expanded || pin0_general) |=> bus_wait_n)
		else $error("wait output not idle while pin general");

	a_exp_strobe_pins: assert property (
		@(posedge sys_clk) disable iff (init)
		((mode == BCP6_MODE1 || mode == BCP6_MODE3 || mode == BCP6_MODE5 || mode == BCP6_MODE6) && !sw_standby)
		|=> (pin_oe_ff[3:1] == 3'h7 && pin_out_ff[3:1] == $past(bus_strobes)))
		else $error("strobes not on pins in expanded mode");

	a_swsb_regs_hold: assert property (
		@(posedge sys_clk) disable iff (init)
		sw_standby |=> ($stable(dir_ff) && $stable(latch_ff)))
		else $error("registers changed in software standby");

	a_dir_write_store: assert property (
		@(posedge sys_clk) disable iff (init)
		(wr_ok && reg_addr == BCP6_ADDR_DIR)
		|=> (dir_ff[BCP6_TOP_BIT-1:0] == $past(reg_wdata[BCP6_TOP_BIT-1:0])))
		else $error("direction write not stored");

	a_pins_init_off: assert property (
		@(posedge sys_clk)
		init |=> (pin_oe_ff == BCP6_PIN_IDLE))
		else $error("pin drivers on after init");

	a_spare_low_store: assert property (
		@(posedge sys_clk) disable iff (init)
		(wr_ok && reg_addr == BCP6_ADDR_LATCH) |=> (latch_ff[2:1] == $past(reg_wdata[2:1])))
		else $error("spare low latch bits not stored");

	a_pin0_general_dir: assert property (
		@(posedge sys_clk) disable iff (init)
		(expanded && pin0_general && !sw_standby)
		|=> (pin_oe_ff[0] == $past(dir_ff[0]) && pin_out_ff[0] == $past(latch_ff[0])))
		else $error("general pin zero ignores direction");

	a_spare_read_latch: assert property (
		@(posedge sys_clk) disable iff (init)
		(reg_rd && reg_addr == BCP6_ADDR_LATCH && dir_ff[6])
		|=> (reg_rdata[6] == $past(latch_ff[6])))
		else $error("spare bit not read from latch");

	a_wait_pin_read: assert property (
		@(posedge sys_clk) disable iff (init)
		(reg_rd && reg_addr == BCP6_ADDR_LATCH && !dir_ff[0])
		|=> (reg_rdata[0] == $past(pin_s[BCP6_PIN_WAIT])))
		else $error("pin zero level not returned");

endmodule

// *** bcp6_pkg.sv ***
package bcp6_pkg;

	// ==========================================================
	// register map
	localparam logic [15:0] BCP6_ADDR_DIR    = 16'hFFC9;
	localparam logic [15:0] BCP6_ADDR_LATCH  = 16'hFFCB;

	// ==========================================================
	// reset and read-back values
	localparam logic [7:0]  BCP6_DIR_RST     = 8'h80;
	localparam logic [7:0]  BCP6_LATCH_RST   = 8'h80;
	localparam logic [7:0]  BCP6_DIR_READ    = 8'hFF;
	localparam logic [7:0]  BCP6_UNMAP_READ  = 8'h00;
	localparam logic [7:0]  BCP6_RDATA_RST   = 8'h00;
	localparam logic        BCP6_FIXED_ONE   = 1'b1;
	localparam logic        BCP6_WAIT_IDLE   = 1'b1;

	// ==========================================================
	// field positions
	localparam int          BCP6_TOP_BIT     = 7;
	localparam int          BCP6_NPINS       = 4;
	localparam int          BCP6_SYNC_W      = 5;
	localparam int          BCP6_SYNC_HWSB   = 4;
	// pin index to register bit position
	localparam int          BCP6_PIN_POS [0:3] = '{0, 3, 4, 5};
	localparam int          BCP6_PIN_WAIT    = 0;
	localparam int          BCP6_PIN_AS      = 1;
	localparam int          BCP6_PIN_RD      = 2;
	localparam int          BCP6_PIN_WR      = 3;
	localparam logic [3:0]  BCP6_PIN_IDLE    = 4'h0;
	localparam logic [7:0]  BCP6_STALL_ALL   = 8'hFF;

	// ==========================================================
	// operating modes
	localparam logic [2:0]  BCP6_MODE1       = 3'h1;
	localparam logic [2:0]  BCP6_MODE3       = 3'h3;
	localparam logic [2:0]  BCP6_MODE5       = 3'h5;
	localparam logic [2:0]  BCP6_MODE6       = 3'h6;
	localparam logic [2:0]  BCP6_MODE7       = 3'h7;

	typedef enum {
		BCP6_SINGLE_CHIP,
		BCP6_EXP_NO_ROM,
		BCP6_EXP_WITH_ROM
	} bcp6_mode_e;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic write_strobe_n;
		logic read_strobe_n;
		logic address_strobe_n;
	} bcp6_strobe_s;

	typedef struct packed {
		logic [7:0] stall_enable_bits;
		logic       stall_mode_select_high;
	} bcp6_stall_s;

endpackage

// *** bcp6_sync2.sv ***
`timescale 1ns/10ps
module bcp6_sync2
	import bcp6_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule

// *** bcp6_pin_load.sv ***
`timescale 1ns/10ps
module bcp6_pin_load
	import bcp6_pkg::*;
(
	input  wire logic [BCP6_NPINS-1:0] pin_out,
	input  wire logic [BCP6_NPINS-1:0] pin_oe,
	input  wire logic [BCP6_NPINS-1:0] ext_lvl,
	output logic      [BCP6_NPINS-1:0] pin_in
);
	// ==========================================================
	// wire level: port driver wins, else the outside device drives
	always_comb
	begin
		for (int i = 0; i < BCP6_NPINS; i++)
		begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
		end
	end
endmodule

// *** tb_bus_control_port_six.sv ***
`timescale 1ns/10ps
module tb_bus_control_port_six;
	import bcp6_pkg::*;
	logic               sys_clk;
	logic               sys_rst;
	logic               hw_standby;
	logic               sw_standby;
	logic [2:0]         mode;
	bcp6_stall_s        stall_cfg;
	bcp6_strobe_s       bus_strobes;
	logic [15:0]        reg_addr;
	logic [7:0]         reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [7:0]         reg_rdata;
	logic [3:0]         pin_in;
	logic [3:0]         pin_out;
	logic [3:0]         pin_oe;
	logic [3:0]         ext_lvl;
	logic [3:0]         po;
	logic               bus_wait_n;
	logic [7:0]         dm;
	logic [7:0]         lm;
	int                 bad_count;
	int                 num_checks;
	logic [7:0]         dir_t [0:2] = '{8'h39, 8'h46, 8'h00};
	logic [7:0]         lat_t [0:2] = '{8'h2E, 8'h15, 8'hFF};
	logic [3:0]         ext_t [0:2] = '{4'h5, 4'hA, 4'h3};
	logic [2:0]         mode_t [0:3] = '{3'h1, 3'h3, 3'h5, 3'h6};

	bcp6_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hw_standby(hw_standby), .sw_standby(sw_standby),
		.mode(mode), .stall_cfg(stall_cfg), .bus_strobes(bus_strobes), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .bus_wait_n(bus_wait_n));
	bcp6_pin_load load (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

	// ==========================================================
	// helpers
	function automatic logic [3:0] pins(input logic [7:0] v);
		pins = {v[5], v[4], v[3], v[0]};
	endfunction

	function automatic logic [7:0] view(input logic [7:0] d, input logic [7:0] l, input logic [3:0] p);
		view = 8'hFF;
		for (int i = 0; i < 8; i++)
		begin
			if (i == 6 || i == 2 || i == 1)
				view[i] = d[i] ? l[i] : 1'b1;
		end
		view[0] = d[0] ? l[0] : p[0];
		view[3] = d[3] ? l[3] : p[1];
		view[4] = d[4] ? l[4] : p[2];
		view[5] = d[5] ? l[5] : p[3];
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic conclude();
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	initial
	begin
		#20000;
		bad_count++;
		conclude();
	end

	// ==========================================================
	// tests
	initial
	begin
		{sys_rst, hw_standby, sw_standby, reg_wr, reg_rd} = 5'b10000;
		{mode, ext_lvl, reg_addr, reg_wdata} = {3'h7, 4'h0, 16'h0000, 8'h00};
		stall_cfg = '{8'hFF, 1'b0};
		bus_strobes = 3'b111;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		tick(1);
		rd(BCP6_ADDR_DIR, 8'hFF);
		rd(BCP6_ADDR_LATCH, view(8'h80, 8'h80, 4'h0));
		chk({4'h0, pin_oe}, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			dm = dir_t[i] | 8'h80;
			lm = lat_t[i] | 8'h80;
			ext_lvl <= ext_t[i];
			wr(BCP6_ADDR_DIR, dir_t[i]);
			wr(BCP6_ADDR_LATCH, lat_t[i]);
			tick(4);
			rd(BCP6_ADDR_LATCH, view(dm, lm, ext_t[i]));
			chk({4'h0, pin_oe}, {4'h0, pins(dm)});
			chk({4'h0, pin_out & pin_oe}, {4'h0, pins(lm) & pins(dm)});
		end
		wr(BCP6_ADDR_DIR, 8'h3F);
		wr(BCP6_ADDR_LATCH, 8'h29);
		tick(3);
		po = pin_out;
		sw_standby <= 1'b1;
		wr(BCP6_ADDR_LATCH, 8'h10);
		wr(BCP6_ADDR_DIR, 8'h00);
		tick(4);
		chk({pin_oe, pin_out}, {4'hF, po});
		rd(BCP6_ADDR_LATCH, view(8'hBF, 8'hA9, 4'h0));
		sw_standby <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			mode <= mode_t[i];
			bus_strobes <= i[0] ? 3'b010 : 3'b101;
			stall_cfg <= '{8'hFF, 1'b0};
			ext_lvl <= {3'h0, i[0]};
			wr(BCP6_ADDR_DIR, 8'h01);
			tick(4);
			chk({4'h0, pin_oe}, 8'h0F);
			chk({4'h0, pin_out}, {4'h0, bus_strobes, 1'b1});
			chk({7'h00, bus_wait_n}, 8'h01);
			wr(BCP6_ADDR_DIR, 8'h00);
			stall_cfg <= i[0] ? bcp6_stall_s'{8'hFF, 1'b1} : bcp6_stall_s'{8'hFE, 1'b0};
			tick(5);
			chk({4'h0, pin_oe}, 8'h0E);
			chk({7'h00, bus_wait_n}, {7'h00, i[0]});
			chk({5'h00, pin_out[3:1]}, {5'h00, bus_strobes});
		end
		mode <= 3'h7;
		ext_lvl <= 4'h0;
		hw_standby <= 1'b1;
		tick(5);
		hw_standby <= 1'b0;
		tick(3);
		rd(BCP6_ADDR_LATCH, view(8'h80, 8'h80, 4'h0));
		chk({4'h0, pin_oe}, 8'h00);
		rd(16'hFFCA, 8'h00);
		conclude();
	end
endmodule
